// [dv/adapter_timing_config_commands_test.sv]
// Self-checking bench of the timing config block
`include "atc_regs.svh"
`default_nettype none
module adapter_timing_config_commands_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 0, srst_i = 1, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata_o, sel_exp;
   logic [7:0] cfg_spd = 0, bsy_dly = 0;
   logic [3:0] rdy_lo = 0;
   logic sel_start = 0, xfer_req = 0, dma_go = 0, dma_rd = 0, ok, er;
   logic pready_o, pslverr_o, sel_err_o, sel_ok_o, bus_own_o, rd_s, wr_s, done_o, bsy, rdy;
   logic [32:0] expq[$];
   int n_errors = 0, check_count = 0, n, seed = 32'ha943;
   logic [31:0] st[3] = '{32'h02000009, 32'h01010009, 32'h01000003};
   logic [7:0] onv[4] = '{8'h10, 8'h0f, 8'h01, 8'h02};
   logic [7:0] offv[4] = '{8'h41, 8'h40, 8'h00, 8'h07};
   logic [7:0] spv[9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'hff, 8'h05, 8'h80, 8'hda};
   logic [7:0] on_e = 8'h0b, off_e = 8'h04;
   always #5 clk_i = ~clk_i;
   atc_timing_cfg #(.MS_CYC(10)) DUT (
      .clk_i(clk_i), .srst_i(srst_i), .ce_i(1'b1), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hf),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .cfg_speed_i(cfg_spd),
      .sel_start_i(sel_start), .scsi_bsy_i(bsy), .sel_err_o(sel_err_o), .sel_ok_o(sel_ok_o),
      .xfer_req_i(xfer_req), .bus_own_o(bus_own_o), .dma_go_i(dma_go), .dma_rd_i(dma_rd),
      .chan_rdy_i(rdy), .dma_rd_strb_o(rd_s), .dma_wr_strb_o(wr_s), .dma_done_o(done_o));
   atc_far_model far (
      .clk_i(clk_i), .sel_start_i(sel_start), .strb_i(rd_s | wr_s), .bsy_dly_i(bsy_dly),
      .rdy_lo_i(rdy_lo), .scsi_bsy_o(bsy), .chan_rdy_o(rdy));
   task stop_test();
      $display("Checks %0d, mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task chk(input logic [32:0] seen, input logic [32:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_i);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk_i);
      penable <= 1;
      do begin
         @(posedge clk_i);
         k++;
      end while (pready_o !== 1'b1 && k < 20);
      if (k >= 20) n_errors++;
      psel <= 0; penable <= 0;
   endtask
   task rd(input logic [11:0] a, input logic [32:0] e);
      expq.push_back(e);
      apb(0, a, 32'h0);
   endtask
   // Whenever a read completes, compare it with the oldest expectation
   always @(posedge clk_i) begin
      if (psel && penable && pready_o === 1'b1 && !pwrite) chk({pslverr_o, prdata_o}, expq.pop_front());
   end
   task cmd(input logic [39:0] b, input int np, input logic bad);
      for (int i = 0; i <= np; i++) begin
         apb(1, `ATC_OFF_CMD, {24'h0, b[39-8*i -: 8]});
         if (i < np) rd(`ATC_OFF_STAT, 33'h4);
      end
      rd(`ATC_OFF_STAT, bad ? 33'h3 : 33'h1);
      apb(1, `ATC_OFF_STAT, 32'h3);
   endtask
   function automatic logic sig(input int w);
      case (w)
         0: return bus_own_o;
         1: return rd_s;
         2: return wr_s;
         default: return done_o;
      endcase
   endfunction
   task span(input int w, input logic lvl, output int c);
      c = 0;
      while (sig(w) === lvl && c < 5000) begin
         @(posedge clk_i);
         c++;
      end
   endtask
   task sel(input logic [7:0] d);
      bsy_dly <= d;
      @(posedge clk_i) sel_start <= 1;
      @(posedge clk_i) sel_start <= 0;
      ok = 0; er = 0; n = 0;
      for (int i = 1; i <= 60; i++) begin
         @(posedge clk_i);
         if (sel_err_o === 1'b1 && !er) begin er = 1; n = i; end
         if (sel_ok_o === 1'b1) ok = 1;
      end
   endtask
   task dma(input logic r, input int w, input int g);
      @(posedge clk_i) begin dma_go <= 1; dma_rd <= r; end
      @(posedge clk_i) dma_go <= 0;
      span(r ? 1 : 2, 0, n);
      span(r ? 1 : 2, 1, n);
      chk(n, w);
      span(3, 0, n);
      chk(n, g);
   endtask
   initial begin
      #600000 n_errors++;
      stop_test();
   end
   initial begin
      cfg_spd <= 8'($random(seed));
      repeat (4) @(posedge clk_i);
      srst_i <= 0;
      sel_exp = 32'h000100fa;
      rd(`ATC_OFF_SEL, sel_exp);
      rd(`ATC_OFF_BUS, 33'h0004040b);
      rd(`ATC_OFF_SPD, {25'h0, cfg_spd});
      rd(12'h020, 33'h100000000);
      cmd(40'h3f00000000, 0, 1);
      foreach (st[i]) begin
         cmd({8'h06, st[i]}, 4, st[i][31:24] > 1 || st[i][23:16] != 0);
         if (i == 2) sel_exp = 32'h00010003;
         rd(`ATC_OFF_SEL, sel_exp);
      end
      sel(0);
      chk(er && n >= 28 && n <= 34 && !ok, 1);
      sel(3);
      chk({ok, er}, 2'b10);
      cmd(40'h0600000003, 4, 0);
      sel(0);
      chk({ok, er}, 2'b00);
      foreach (onv[i]) begin
         cmd({8'h07, onv[i], 24'h0}, 1, onv[i] < 2 || onv[i] > 15);
         if (onv[i] >= 2 && onv[i] <= 15) on_e = onv[i];
         if (offv[i] <= 64) off_e = offv[i];
         cmd({8'h08, offv[i], 24'h0}, 1, offv[i] > 64);
         rd(`ATC_OFF_BUS, {9'h0, (off_e < 4) ? 8'h01 : (off_e & 8'hfc), off_e, on_e});
      end
      xfer_req <= 1;
      span(0, 0, n);
      span(0, 1, n);
      chk(n, 200);
      span(0, 0, n);
      chk(n, 401);
      xfer_req <= 0;
      foreach (spv[i]) begin
         cmd({8'h09, spv[i], 24'h0}, 1, spv[i] == 8'h05);
         if (spv[i] != 8'h05) rd(`ATC_OFF_SPD, {25'h1, spv[i]});
      end
      cmd(40'h07_0f000000, 1, 0);
      repeat (500) @(posedge clk_i);
      xfer_req <= 1;
      span(0, 0, n);
      dma(1, 35, 15);
      rdy_lo <= 4;
      dma(1, 39, 15);
      rdy_lo <= 0;
      dma(0, 20, 15);
      cmd(40'h0903000000, 1, 0);
      dma(0, 10, 10);
      xfer_req <= 0;
      repeat (5) @(posedge clk_i);
      stop_test();
   end
endmodule
`default_nettype wire

// [dv/atc_far_model.sv]
// Target and host memory model: answers selection with BSY and throttles channel ready
`default_nettype none
module atc_far_model (
   input  wire logic       clk_i,
   input  wire logic       sel_start_i,
   input  wire logic       strb_i,
   input  wire logic [7:0] bsy_dly_i,
   input  wire logic [3:0] rdy_lo_i,
   output logic            scsi_bsy_o,
   output logic            chan_rdy_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] bcnt = 8'hff;
   logic [3:0] rcnt = 4'h0;
   logic       strb_q = 1'b0;
   always @(posedge clk_i) begin
      strb_q <= strb_i;
      if (sel_start_i) begin
         bcnt <= 8'h01;
      end else if (bcnt != 8'hff) begin
         bcnt <= bcnt + 8'h01;
      end
      if (strb_i && !strb_q) begin
         rcnt <= rdy_lo_i;
      end else if (rcnt != 4'h0) begin
         rcnt <= rcnt - 4'h1;
      end
   end
   // Zero delay: target never answers
   assign scsi_bsy_o = (bsy_dly_i != 8'h00) && (bcnt >= bsy_dly_i) && (bcnt < bsy_dly_i + 8'h08);
   assign chan_rdy_o = (rcnt == 4'h0);
endmodule
`default_nettype wire

// [verilog/atc_pkg.sv]
// Types of the timing config block
`default_nettype none
package atc_pkg;
   typedef enum logic [1:0] {BUS_IDLE, BUS_ON, BUS_OFF} atc_bus_st_t;
   typedef enum logic [1:0] {DMA_IDLE, DMA_STRB, DMA_GAP} atc_dma_st_t;
   typedef struct packed {
      logic [2:0]  need;
      logic [7:0]  op;
      logic [7:0]  p0;
      logic [7:0]  p1;
      logic [7:0]  p2;
      logic        cmpl;
      logic        inv;
      logic        sel_en;
      logic [15:0] sel_ms;
      logic [7:0]  on_us;
      logic [7:0]  off_us;
      logic [7:0]  spd;
      logic        spd_ovr;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
      logic        bsy_m;
      logic        bsy_s;
      logic        rdy_m;
      logic        rdy_s;
      logic        sel_act;
      logic [16:0] sel_pre;
      logic [15:0] sel_cnt;
      logic        sel_err;
      logic        sel_ok;
      atc_bus_st_t bst;
      logic [12:0] bcnt;
      logic        bus_own;
      atc_dma_st_t dst;
      logic [5:0]  dcnt;
      logic        strb_rd;
      logic        strb_wr;
      logic        dma_done;
   } atc_state_t;
endpackage
`default_nettype wire

// [verilog/atc_regs.svh]
// Register offsets, field positions, reset values and timing figures of the timing config block
`ifndef ATC_REGS_SVH
`define ATC_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define ATC_OFF_CMD      12'h000
`define ATC_OFF_STAT     12'h004
`define ATC_OFF_SEL      12'h008
`define ATC_OFF_BUS      12'h00c
`define ATC_OFF_SPD      12'h010

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ATC_ST_CMPL      0
`define ATC_ST_INV       1
`define ATC_ST_BUSY      2
`define ATC_SEL_EN_BIT   16
`define ATC_SPD_OVR_BIT  8
`define ATC_SPD_CUST_BIT 7
`define ATC_SPD_GAP_BIT  3

// ----------------------------------------------------------------------
// Opcodes, parameter counts and value limits
// ----------------------------------------------------------------------
`define ATC_OP_SELTO     8'h06
`define ATC_OP_BUSON     8'h07
`define ATC_OP_BUSOFF    8'h08
`define ATC_OP_SPEED     8'h09
`define ATC_SELTO_NPARM  3'h4
`define ATC_ONE_NPARM    3'h1
`define ATC_SEL_OFF      8'h00
`define ATC_SEL_ON       8'h01
`define ATC_ON_MIN       8'h02
`define ATC_ON_MAX       8'h0f
`define ATC_OFF_MAX      8'h40
`define ATC_OFF_MASK     8'hfc
`define ATC_OFF_MIN_US   8'h01
`define ATC_SPD_FIX_MAX  8'h04
`define ATC_SPD_SLOW     8'hff

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ATC_SEL_EN_RST   1'b1
`define ATC_SEL_MS_RST   16'h00fa
`define ATC_ON_RST       8'h0b
`define ATC_OFF_RST      8'h04

// ----------------------------------------------------------------------
// Times in ns; cycle counts are derived in the module
// ----------------------------------------------------------------------
`define ATC_CLK_NS       10
`define ATC_US_NS        1000
`define ATC_MS_NS        1000000
`define ATC_STRB_BASE_NS 100
`define ATC_STRB_STEP_NS 50
`define ATC_GAP_NS       100
`define ATC_GAP_LONG_NS  150
`define ATC_PER0_NS      400
`define ATC_PER1_NS      300
`define ATC_PER2_NS      250
`define ATC_PER3_NS      200
`define ATC_PER4_NS      350
`define ATC_PERFF_NS     600

`endif

// [verilog/atc_timing_cfg.sv]
// Timing configuration command interpreter with selection timer, bus pacer and DMA strobes
//
// Function
// - Selection-timeout command 06h takes four parameter bytes, all gathered before use.
// - Byte 0: 00h disables timeout, 01h enables it with bytes 2 and 3.
// - Selection timeout comes out of reset enabled.
// - Bytes 2 (high) and 3 (low) give timeout in ms; reset value 250.
// - Enabled timeout without BSY abandons selection and reports selection error.
// - Byte 0 not 00h/01h or byte 1 nonzero is invalid; else complete.
// - Bus-on command 07h takes one byte in us; reset value 11.
// - Bus-on value below 2 or above 15 is invalid; else accepted.
// - Bus master holds the bus no longer than the on-time.
// - Bus-off command 08h takes one byte in us; reset value 4.
// - Bus-off value above 64 is invalid; else accepted.
// - Off-time rounds down to a multiple of 4 us, at least about 1 us.
// - Speed command 09h: codes 00h-04h fixed rates, FFh slowest rate.
// - Custom speed bits 6-4 set read strobe to 100 ns plus 50 ns steps.
// - Custom speed bit 3 sets strobe inactive time 100 or 150 ns.
// - Custom speed bits 2-0 set write strobe to 100 ns plus 50 ns steps.
// - DMA strobe is stretched while channel ready is low.
// - Stored speed applies until speed command overrides it; then complete.
// - An invalid command also sets the completion flag.
//
// Decided for this implementation: register access over APB and the placing of the registers.
`include "atc_regs.svh"
`default_nettype none
module atc_timing_cfg #(
   parameter int MS_CYC = `ATC_MS_NS / `ATC_CLK_NS
) (
   input  wire logic        clk_i,
   input  wire logic        srst_i,
   input  wire logic        ce_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   input  wire logic [3:0]  pstrb_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic [7:0]  cfg_speed_i,
   input  wire logic        sel_start_i,
   input  wire logic        scsi_bsy_i,
   output logic             sel_err_o,
   output logic             sel_ok_o,
   input  wire logic        xfer_req_i,
   output logic             bus_own_o,
   input  wire logic        dma_go_i,
   input  wire logic        dma_rd_i,
   input  wire logic        chan_rdy_i,
   output logic             dma_rd_strb_o,
   output logic             dma_wr_strb_o,
   output logic             dma_done_o
);
   import atc_pkg::*;

   // ----------------------------------------------------------------------
   // Derived cycle counts and parameter check
   // ----------------------------------------------------------------------
   localparam int CYC_US = `ATC_US_NS / `ATC_CLK_NS;

   generate
      if (MS_CYC < 1 || MS_CYC > 131072) begin : g_bad_ms
         $error("MS_CYC must lie between 1 and 131072");
      end
   endgenerate

   localparam atc_state_t ST_RST = '{sel_en: `ATC_SEL_EN_RST, sel_ms: `ATC_SEL_MS_RST,
                                     on_us: `ATC_ON_RST, off_us: `ATC_OFF_RST,
                                     bst: BUS_IDLE, dst: DMA_IDLE, default: '0};

   atc_state_t r;
   atc_state_t n;

   // Strobe width in cycles for the given speed byte and direction
   function automatic logic [5:0] strb_cyc(input logic [7:0] s, input logic rd);
      int ns;
      ns = `ATC_PER0_NS - `ATC_GAP_NS;
      if (s == `ATC_SPD_SLOW) begin
         ns = `ATC_PERFF_NS - `ATC_GAP_NS;
      end else if (s[`ATC_SPD_CUST_BIT]) begin
         ns = `ATC_STRB_BASE_NS + `ATC_STRB_STEP_NS * int'(rd ? s[6:4] : s[2:0]);
      end else begin
         case (s[2:0])
            3'h1:    ns = `ATC_PER1_NS - `ATC_GAP_NS;
            3'h2:    ns = `ATC_PER2_NS - `ATC_GAP_NS;
            3'h3:    ns = `ATC_PER3_NS - `ATC_GAP_NS;
            3'h4:    ns = `ATC_PER4_NS - `ATC_GAP_NS;
            default: ns = `ATC_PER0_NS - `ATC_GAP_NS;
         endcase
      end
      return 6'(ns / `ATC_CLK_NS);
   endfunction

   // Strobe inactive time in cycles
   function automatic logic [5:0] gap_cyc(input logic [7:0] s);
      int ns;
      ns = `ATC_GAP_NS;
      if (s[`ATC_SPD_CUST_BIT] && s != `ATC_SPD_SLOW && s[`ATC_SPD_GAP_BIT]) begin
         ns = `ATC_GAP_LONG_NS;
      end
      return 6'(ns / `ATC_CLK_NS);
   endfunction

   // ----------------------------------------------------------------------
   // Combinational helpers
   // ----------------------------------------------------------------------
   logic        acc;
   logic        wr_cmd;
   logic        wr_stat;
   logic [7:0]  wb;
   logic [7:0]  off_eff;
   logic [7:0]  spd_eff;
   logic [12:0] on_cyc;
   logic [12:0] off_cyc;

   assign acc     = psel_i && penable_i && r.pready && pwrite_i && !r.pslverr;
   assign wr_cmd  = acc && paddr_i == `ATC_OFF_CMD && pstrb_i[0];
   assign wr_stat = acc && paddr_i == `ATC_OFF_STAT && pstrb_i[0];
   assign wb      = pwdata_i[7:0];
   assign off_eff = ((r.off_us & `ATC_OFF_MASK) == 8'h00) ? `ATC_OFF_MIN_US
                                                          : (r.off_us & `ATC_OFF_MASK);
   assign spd_eff = r.spd_ovr ? r.spd : cfg_speed_i;
   assign on_cyc  = 13'(int'(r.on_us) * CYC_US);
   assign off_cyc = 13'(int'(off_eff) * CYC_US);

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      n = r;
      n.bsy_m    = scsi_bsy_i;
      n.bsy_s    = r.bsy_m;
      n.rdy_m    = chan_rdy_i;
      n.rdy_s    = r.rdy_m;
      n.sel_err  = 1'b0;
      n.sel_ok   = 1'b0;
      n.dma_done = 1'b0;

      // APB: read data and error are prepared in the setup cycle
      n.pready  = 1'b0;
      n.pslverr = 1'b0;
      if (psel_i && !penable_i) begin
         n.pready  = 1'b1;
         n.pslverr = 1'b0;
         n.prdata  = 32'h0000_0000;
         if (paddr_i == `ATC_OFF_CMD) begin
            n.prdata = 32'h0000_0000;
         end else if (paddr_i == `ATC_OFF_STAT) begin
            n.prdata[`ATC_ST_CMPL] = r.cmpl;
            n.prdata[`ATC_ST_INV]  = r.inv;
            n.prdata[`ATC_ST_BUSY] = r.need != 3'h0;
         end else if (paddr_i == `ATC_OFF_SEL) begin
            n.prdata[15:0]            = r.sel_ms;
            n.prdata[`ATC_SEL_EN_BIT] = r.sel_en;
         end else if (paddr_i == `ATC_OFF_BUS) begin
            n.prdata[7:0]   = r.on_us;
            n.prdata[15:8]  = r.off_us;
            n.prdata[23:16] = off_eff;
         end else if (paddr_i == `ATC_OFF_SPD) begin
            n.prdata[7:0]              = spd_eff;
            n.prdata[`ATC_SPD_OVR_BIT] = r.spd_ovr;
         end else begin
            n.pslverr = 1'b1;
         end
      end

      // Flag clear by writing ones; command sets below win
      if (wr_stat) begin
         if (pwdata_i[`ATC_ST_CMPL]) begin
            n.cmpl = 1'b0;
         end
         if (pwdata_i[`ATC_ST_INV]) begin
            n.inv = 1'b0;
         end
      end

      // Command byte stream
      if (wr_cmd) begin
         if (r.need == 3'h0) begin
            n.op = wb;
            if (wb == `ATC_OP_SELTO) begin
               n.need = `ATC_SELTO_NPARM;
            end else if (wb == `ATC_OP_BUSON || wb == `ATC_OP_BUSOFF
                         || wb == `ATC_OP_SPEED) begin
               n.need = `ATC_ONE_NPARM;
            end else begin
               n.cmpl = 1'b1;
               n.inv  = 1'b1;
            end
         end else begin
            n.need = r.need - 3'h1;
            n.p0   = r.p1;
            n.p1   = r.p2;
            n.p2   = wb;
            if (r.need == 3'h1) begin
               n.cmpl = 1'b1;
               case (r.op)
                  `ATC_OP_SELTO: begin
                     if ((r.p0 == `ATC_SEL_OFF || r.p0 == `ATC_SEL_ON)
                         && r.p1 == 8'h00) begin
                        n.sel_en = r.p0 == `ATC_SEL_ON;
                        n.sel_ms = {r.p2, wb};
                     end else begin
                        n.inv = 1'b1;
                     end
                  end
                  `ATC_OP_BUSON: begin
                     if (wb < `ATC_ON_MIN || wb > `ATC_ON_MAX) begin
                        n.inv = 1'b1;
                     end else begin
                        n.on_us = wb;
                     end
                  end
                  `ATC_OP_BUSOFF: begin
                     if (wb > `ATC_OFF_MAX) begin
                        n.inv = 1'b1;
                     end else begin
                        n.off_us = wb;
                     end
                  end
                  default: begin
                     if (wb <= `ATC_SPD_FIX_MAX || wb[`ATC_SPD_CUST_BIT]) begin
                        n.spd     = wb;
                        n.spd_ovr = 1'b1;
                     end else begin
                        n.inv = 1'b1;
                     end
                  end
               endcase
            end
         end
      end

      // Selection timer
      if (sel_start_i) begin
         n.sel_act = 1'b1;
         n.sel_pre = '0;
         n.sel_cnt = '0;
      end else if (r.sel_act) begin
         if (r.bsy_s) begin
            n.sel_act = 1'b0;
            n.sel_ok  = 1'b1;
         end else if (r.sel_en) begin
            if (r.sel_cnt >= r.sel_ms) begin
               n.sel_act = 1'b0;
               n.sel_err = 1'b1;
            end else if (r.sel_pre == 17'(MS_CYC - 1)) begin
               n.sel_pre = '0;
               n.sel_cnt = r.sel_cnt + 16'h0001;
            end else begin
               n.sel_pre = r.sel_pre + 17'h00001;
            end
         end
      end

      // Bus-on / bus-off pacer
      case (r.bst)
         BUS_IDLE: begin
            if (xfer_req_i) begin
               n.bst     = BUS_ON;
               n.bus_own = 1'b1;
               n.bcnt    = on_cyc - 13'h0001;
            end
         end
         BUS_ON: begin
            if (!xfer_req_i || r.bcnt == 13'h0000) begin
               n.bst     = BUS_OFF;
               n.bus_own = 1'b0;
               n.bcnt    = off_cyc - 13'h0001;
            end else begin
               n.bcnt = r.bcnt - 13'h0001;
            end
         end
         default: begin
            if (r.bcnt == 13'h0000) begin
               n.bst = BUS_IDLE;
            end else begin
               n.bcnt = r.bcnt - 13'h0001;
            end
         end
      endcase

      // DMA strobe timing, started only while the bus is held
      case (r.dst)
         DMA_IDLE: begin
            if (dma_go_i && r.bus_own) begin
               n.dst     = DMA_STRB;
               n.strb_rd = dma_rd_i;
               n.strb_wr = !dma_rd_i;
               n.dcnt    = strb_cyc(spd_eff, dma_rd_i) - 6'h01;
            end
         end
         DMA_STRB: begin
            if (!r.rdy_s) begin
               n.dcnt = r.dcnt;
            end else if (r.dcnt == 6'h00) begin
               n.dst     = DMA_GAP;
               n.strb_rd = 1'b0;
               n.strb_wr = 1'b0;
               n.dcnt    = gap_cyc(spd_eff) - 6'h01;
            end else begin
               n.dcnt = r.dcnt - 6'h01;
            end
         end
         default: begin
            if (r.dcnt == 6'h00) begin
               n.dst      = DMA_IDLE;
               n.dma_done = 1'b1;
            end else begin
               n.dcnt = r.dcnt - 6'h01;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         r <= ST_RST;
      end else if (ce_i) begin
         r <= n;
      end
   end

   assign prdata_o      = r.prdata;
   assign pready_o      = r.pready;
   assign pslverr_o     = r.pslverr;
   assign sel_err_o     = r.sel_err;
   assign sel_ok_o      = r.sel_ok;
   assign bus_own_o     = r.bus_own;
   assign dma_rd_strb_o = r.strb_rd;
   assign dma_wr_strb_o = r.strb_wr;
   assign dma_done_o    = r.dma_done;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);

   logic [13:0] own_len;
   logic [12:0] own_lim;
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         own_len <= '0;
         own_lim <= '0;
      end else if (ce_i) begin
         own_len <= n.bus_own ? own_len + 14'h0001 : 14'h0000;
         if (!r.bus_own && n.bus_own) begin
            own_lim <= on_cyc;
         end
      end
   end

   property p_rst_dflt;
      $fell(srst_i) |-> r.sel_en && r.sel_ms == `ATC_SEL_MS_RST
         && r.on_us == `ATC_ON_RST && r.off_us == `ATC_OFF_RST && !r.spd_ovr;
   endproperty
   a_rst_dflt: assert property (p_rst_dflt) else $error("bad reset values");

   property p_no_early_flag;
      (ce_i && r.need > 3'h1 && !r.cmpl && !r.inv) |=> !r.cmpl && !r.inv;
   endproperty
   a_no_early_flag: assert property (p_no_early_flag) else $error("flag before last byte");

   property p_inv_cmpl;
      $rose(r.inv) |-> r.cmpl;
   endproperty
   a_inv_cmpl: assert property (p_inv_cmpl) else $error("invalid without complete");

   property p_on_range;
      r.on_us >= `ATC_ON_MIN && r.on_us <= `ATC_ON_MAX;
   endproperty
   a_on_range: assert property (p_on_range) else $error("bus-on out of range");

   property p_off_range;
      r.off_us <= `ATC_OFF_MAX;
   endproperty
   a_off_range: assert property (p_off_range) else $error("bus-off out of range");

   property p_off_load;
      (ce_i && r.bst == BUS_ON && !n.bus_own)
         |=> r.bcnt == 13'(int'($past(off_eff)) * CYC_US - 1)
            && ($past(off_eff) == `ATC_OFF_MIN_US || $past(off_eff[1:0]) == 2'h0);
   endproperty
   a_off_load: assert property (p_off_load) else $error("wrong off time");

   property p_own_max;
      r.bus_own |-> own_len <= 14'(own_lim);
   endproperty
   a_own_max: assert property (p_own_max) else $error("bus held too long");

   property p_stretch;
      (ce_i && r.dst == DMA_STRB && !r.rdy_s) |=> r.dst == DMA_STRB && $stable(r.dcnt);
   endproperty
   a_stretch: assert property (p_stretch) else $error("strobe not stretched");

   property p_sel_dis;
      (ce_i && !r.sel_en) |=> !r.sel_err;
   endproperty
   a_sel_dis: assert property (p_sel_dis) else $error("timeout while disabled");

   property p_sel_err;
      $rose(r.sel_err) |-> $past(r.sel_act) && !$past(r.bsy_s)
         && $past(r.sel_cnt) >= $past(r.sel_ms);
   endproperty
   a_sel_err: assert property (p_sel_err) else $error("selection error without cause");

   property p_spd_src;
      !r.spd_ovr |-> spd_eff == cfg_speed_i;
   endproperty
   a_spd_src: assert property (p_spd_src) else $error("stored speed not used");

   c_inv:   cover property ($rose(r.inv));
   c_selto: cover property ($rose(r.sel_err));
   c_off:   cover property (r.bst == BUS_OFF);
   c_str:   cover property (r.dst == DMA_STRB && !r.rdy_s);
endmodule
`default_nettype wire
